// File: hdl/sfr_space_decoder.sv
// Special-register space decoder for an 8051-class core, upper 128 direct locations.
// Assumes the core presents one access per cycle on ref_clk and peripherals are synchronous.
// What this block does
// RULE1 - Registers occupy direct addresses 80h to FFh, apart from indirect RAM.
// RULE2 - Only direct-addressed accesses reach the registers; indirect ones are ignored.
// RULE3 - Only registers at addresses ending 0h or 8h accept bit instructions.
// RULE4 - A bit write changes just the chosen bit of its register; a bit write to protected D8h forwards its other bits as zero.
// RULE5 - Software leaves reserved addresses alone and never writes them.
// RULE6 - Protected registers accept writes only under timed-access unlock.
// RULE7 - Standard registers stay at usual addresses; additions fill unused slots.
// RULE8 - Unused addresses read zero; writes to them change nothing.
`include "sfr_space_params.svh"
`timescale 1ns/1ns
`default_nettype none

module sfr_space_decoder (
  input  wire logic                      ref_clk,    // Core clock, 250 MHz
  input  wire logic                      rst,        // Async reset, active high
  input  wire sfr_space_pkg::sfr_req_t   req,        // Core access
  input  wire logic                      timed_access_open, // Timed-access window open
  input  wire sfr_space_pkg::periph_in_t periph,     // Peripheral status
  output logic [7:0]                     rdata,      // Read data, registered
  output logic                           rvalid,     // Read data valid pulse
  output logic                           prot_we,    // Write strobe to protected reg
  output logic [7:0]                     prot_addr,  // Protected register address
  output logic [7:0]                     prot_wdata, // Protected register data
  output logic [63:0]                    ctrl_out,   // Control register image
  output logic                           conv_start  // Conversion start pulse
);

  // ==========================================================
  // Decode
  // ==========================================================
  logic       hit;
  logic [7:0] byte_addr;
  logic       bit_ok;
  logic       prot_hit;

  // Bit addresses 80h..FFh name bit [2:0] of register {addr[7:3],000}
  always_comb begin
    hit       = req.valid && req.direct && req.addr >= `SFR_BASE;             // RULE1 RULE2
    byte_addr = req.bit_op ? {req.addr[7:3], `SFR_BIT_LOW_NIBBLE0} : req.addr; // RULE3
    bit_ok    = !req.bit_op || (req.addr >= `SFR_BASE);                        // RULE3
    // Guarded registers live elsewhere; only a forwarded strobe reaches them
    prot_hit  = (byte_addr == `SFR_WDOG_CTRL_A) ||
                (byte_addr == `SFR_WDOG_CTRL_B) ||
                (byte_addr == `SFR_POWER_MON)   ||
                (byte_addr == `SFR_FLASH_TRIG)  ||
                (byte_addr == `SFR_DFLASH_BASE) ||
                (byte_addr == `SFR_CHIP_CTRL);                                 // RULE6
  end

  // ==========================================================
  // Register state
  // ==========================================================
  logic [7:0] extra_irq_enable, keypad_irq_enable, keypad_irq_flags;
  logic [7:0] keypad_level_sel0, keypad_level_sel1, multiply_aux;
  logic [7:0] serial_periph_control, serial_periph_status, serial_periph_data;
  logic [7:0] port0_input_disable, extra_irq_prio_high, converter_control0, extra_irq_priority;
  logic [7:0] next_extra_irq_enable, next_keypad_irq_enable, next_keypad_irq_flags;
  logic [7:0] next_keypad_level_sel0, next_keypad_level_sel1, next_multiply_aux;
  logic [7:0] next_serial_periph_control, next_serial_periph_status, next_serial_periph_data;
  logic [7:0] next_port0_input_disable, next_extra_irq_prio_high, next_converter_control0;
  logic [7:0] next_extra_irq_priority;
  logic [7:0] cur;       // Current value of addressed register
  logic [7:0] wval;      // Value to store after merge
  logic       we;

  // Current value, zero for unmapped or peripheral-owned holes
  always_comb begin
    case (byte_addr)
      `SFR_CAP0_LOW:      cur = periph.cap0_low;
      `SFR_CAP0_HIGH:     cur = periph.cap0_high;
      `SFR_CAP1_LOW:      cur = periph.cap1_low;
      `SFR_CAP1_HIGH:     cur = periph.cap1_high;
      `SFR_CAP2_LOW:      cur = periph.cap2_low;
      `SFR_CAP2_HIGH:     cur = periph.cap2_high;
      `SFR_EXTRA_IRQ_EN:  cur = extra_irq_enable;
      `SFR_KEYPAD_IRQ_EN: cur = keypad_irq_enable;
      `SFR_KEYPAD_FLAGS:  cur = keypad_irq_flags;
      `SFR_KEYPAD_LVL0:   cur = keypad_level_sel0;
      `SFR_KEYPAD_LVL1:   cur = keypad_level_sel1;
      `SFR_MULT_AUX:      cur = multiply_aux;
      `SFR_SPI_CONTROL:   cur = serial_periph_control;
      `SFR_SPI_STATUS:    cur = serial_periph_status;
      `SFR_SPI_DATA:      cur = serial_periph_data;
      `SFR_P0_IN_DISABLE: cur = port0_input_disable;
      `SFR_EXTRA_PRIO_HI: cur = extra_irq_prio_high;
      `SFR_CONV_CONTROL0: cur = converter_control0;
      `SFR_EXTRA_PRIO:    cur = extra_irq_priority;
      default:            cur = `RST_ZERO;                    // RULE8
    endcase
  end

  // Bit writes merge into the current value so neighbours survive, except at protected D8h, whose other bits go out as zero
  always_comb begin
    we   = hit && req.write && bit_ok;
    wval = req.wdata;
    if (req.bit_op) begin
      wval = cur;                                             // RULE4
      wval[req.addr[2:0]] = req.wdata[0];                     // RULE4
    end
  end

  // Next values; hardware set strobes win over a same-cycle software clear
  always_comb begin
    next_extra_irq_enable      = extra_irq_enable;
    next_keypad_irq_enable     = keypad_irq_enable;
    next_keypad_irq_flags      = keypad_irq_flags;
    next_keypad_level_sel0     = keypad_level_sel0;
    next_keypad_level_sel1     = keypad_level_sel1;
    next_multiply_aux          = multiply_aux;
    next_serial_periph_control = serial_periph_control;
    next_serial_periph_status  = serial_periph_status;
    next_serial_periph_data    = serial_periph_data;
    next_port0_input_disable   = port0_input_disable;
    next_extra_irq_prio_high   = extra_irq_prio_high;
    next_converter_control0    = converter_control0;
    next_extra_irq_priority    = extra_irq_priority;
    if (we) begin
      case (byte_addr)                                        // RULE7
        `SFR_EXTRA_IRQ_EN:  next_extra_irq_enable      = wval;
        `SFR_KEYPAD_IRQ_EN: next_keypad_irq_enable     = wval;
        `SFR_KEYPAD_FLAGS:  next_keypad_irq_flags      = wval;
        `SFR_KEYPAD_LVL0:   next_keypad_level_sel0     = wval;
        `SFR_KEYPAD_LVL1:   next_keypad_level_sel1     = wval;
        `SFR_MULT_AUX:      next_multiply_aux          = wval;
        `SFR_SPI_CONTROL:   next_serial_periph_control = wval;
        `SFR_SPI_STATUS:    next_serial_periph_status  = wval & `SPI_STATUS_WMASK;
        `SFR_SPI_DATA:      next_serial_periph_data    = wval;
        `SFR_P0_IN_DISABLE: next_port0_input_disable   = wval;
        `SFR_EXTRA_PRIO_HI: next_extra_irq_prio_high   = wval;
        `SFR_CONV_CONTROL0: next_converter_control0    =
          (converter_control0 & ~`CONV_CTRL0_WMASK) | (wval & `CONV_CTRL0_WMASK);
        `SFR_EXTRA_PRIO:    next_extra_irq_priority    = wval;
        default:            next_extra_irq_priority    = extra_irq_priority; // RULE8
      endcase
    end
    // Peripheral events, applied last so the set wins
    next_keypad_irq_flags          = next_keypad_irq_flags | periph.keypad_set;
    next_serial_periph_status[7:3] = next_serial_periph_status[7:3] | periph.spi_set;
    next_converter_control0[7:6]   = next_converter_control0[7:6] | periph.conv_set;
    if (periph.conv_done) begin
      next_converter_control0[`CONV_START_BIT] = 1'b0;        // Start self-clears
      next_converter_control0[`CONV_DONE_BIT]  = 1'b1;
    end
  end

  // Registers only
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      extra_irq_enable      <= `RST_ZERO;
      keypad_irq_enable     <= `RST_ZERO;
      keypad_irq_flags      <= `RST_ZERO;
      keypad_level_sel0     <= `RST_ZERO;
      keypad_level_sel1     <= `RST_ZERO;
      multiply_aux          <= `RST_ZERO;
      serial_periph_control <= `RST_SPI_CONTROL;
      serial_periph_status  <= `RST_ZERO;
      serial_periph_data    <= `RST_ZERO;
      port0_input_disable   <= `RST_P0_IN_DISABLE;
      extra_irq_prio_high   <= `RST_ZERO;
      converter_control0    <= `RST_ZERO;
      extra_irq_priority    <= `RST_ZERO;
    end else begin
      extra_irq_enable      <= next_extra_irq_enable;
      keypad_irq_enable     <= next_keypad_irq_enable;
      keypad_irq_flags      <= next_keypad_irq_flags;
      keypad_level_sel0     <= next_keypad_level_sel0;
      keypad_level_sel1     <= next_keypad_level_sel1;
      multiply_aux          <= next_multiply_aux;
      serial_periph_control <= next_serial_periph_control;
      serial_periph_status  <= next_serial_periph_status;
      serial_periph_data    <= next_serial_periph_data;
      port0_input_disable   <= next_port0_input_disable;
      extra_irq_prio_high   <= next_extra_irq_prio_high;
      converter_control0    <= next_converter_control0;
      extra_irq_priority    <= next_extra_irq_priority;
    end
  end

  // ==========================================================
  // Read port, protected write port, start strobe
  // ==========================================================
  logic [7:0] next_rdata;
  logic       next_rvalid;
  logic       next_prot_we;
  logic [7:0] next_prot_addr;
  logic [7:0] next_prot_wdata;
  logic       next_conv_start;

  // Protected writes leave only while the unlock window is open
  always_comb begin
    next_rvalid     = hit && !req.write && bit_ok;
    next_rdata      = next_rvalid ? (req.bit_op ? {7'h00, cur[req.addr[2:0]]} : cur)
                                  : `RST_ZERO;
    next_prot_we    = we && prot_hit && timed_access_open;    // RULE6
    next_prot_addr  = next_prot_we ? byte_addr : `RST_ZERO;
    next_prot_wdata = next_prot_we ? wval : `RST_ZERO;
    next_conv_start = we && (byte_addr == `SFR_CONV_CONTROL0) &&
                      wval[`CONV_START_BIT];
  end

  // Outputs leave flip-flops so the core never sees decode glitches
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata      <= `RST_ZERO;
      rvalid     <= 1'b0;
      prot_we    <= 1'b0;
      prot_addr  <= `RST_ZERO;
      prot_wdata <= `RST_ZERO;
      conv_start <= 1'b0;
    end else begin
      rdata      <= next_rdata;
      rvalid     <= next_rvalid;
      prot_we    <= next_prot_we;
      prot_addr  <= next_prot_addr;
      prot_wdata <= next_prot_wdata;
      conv_start <= next_conv_start;
    end
  end

  // Control image for peripherals, high byte first
  assign ctrl_out = {serial_periph_control, extra_irq_priority, extra_irq_prio_high,
                     port0_input_disable, keypad_level_sel1, keypad_level_sel0,
                     keypad_irq_enable, extra_irq_enable};

endmodule : sfr_space_decoder

`default_nettype wire

// File: hdl/sfr_space_params.svh
// Offsets, reset values and field positions of the special-register space.
// Assumes inclusion by bare name from the decoder.
`ifndef SFR_SPACE_PARAMS_SVH
`define SFR_SPACE_PARAMS_SVH

`define SFR_BASE            8'h80
`define SFR_BIT_LOW_NIBBLE0 3'h0
`define SFR_CAP0_LOW        8'he4
`define SFR_CAP0_HIGH       8'he5
`define SFR_CAP1_LOW        8'he6
`define SFR_CAP1_HIGH       8'he7
`define SFR_EXTRA_IRQ_EN    8'he8
`define SFR_KEYPAD_IRQ_EN   8'he9
`define SFR_KEYPAD_FLAGS    8'hea
`define SFR_KEYPAD_LVL0     8'heb
`define SFR_KEYPAD_LVL1     8'hec
`define SFR_CAP2_LOW        8'hed
`define SFR_CAP2_HIGH       8'hee
`define SFR_MULT_AUX        8'hf0
`define SFR_SPI_CONTROL     8'hf3
`define SFR_SPI_STATUS      8'hf4
`define SFR_SPI_DATA        8'hf5
`define SFR_P0_IN_DISABLE   8'hf6
`define SFR_EXTRA_PRIO_HI   8'hf7
`define SFR_CONV_CONTROL0   8'hf8
`define SFR_EXTRA_PRIO      8'hff
// Timed-access guarded registers, stored outside this block
`define SFR_WDOG_CTRL_A     8'hd8
`define SFR_WDOG_CTRL_B     8'hab
`define SFR_POWER_MON       8'ha3
`define SFR_FLASH_TRIG      8'ha4
`define SFR_DFLASH_BASE     8'h9c
`define SFR_CHIP_CTRL       8'h9f

`define RST_ZERO            8'h00
`define RST_SPI_CONTROL     8'h04
`define RST_P0_IN_DISABLE   8'h00
// Writable bits of mixed registers
`define SPI_STATUS_WMASK    8'hf8
`define CONV_CTRL0_WMASK    8'h3f
`define CONV_START_BIT      3
`define CONV_DONE_BIT       4

`endif

// File: hdl/sfr_space_pkg.sv
// Types shared by the special-register decoder and its bench.
// Assumes sfr_space_params.svh sits on the include path.
package sfr_space_pkg;
  // One core access to the special-register space
  typedef struct packed {
    logic       valid;    // Access this cycle
    logic       write;    // Write, else read
    logic       direct;   // Direct addressing
    logic       bit_op;   // Single-bit access
    logic [7:0] addr;     // Byte address, or bit address when bit_op
    logic [7:0] wdata;    // Byte data; bit 0 is the bit value
  } sfr_req_t;

  // Status pushed in from peripherals
  typedef struct packed {
    logic [7:0] cap0_low;
    logic [7:0] cap0_high;
    logic [7:0] cap1_low;
    logic [7:0] cap1_high;
    logic [7:0] cap2_low;
    logic [7:0] cap2_high;
    logic [7:0] keypad_set;   // Keypad flag set strobes
    logic [4:0] spi_set;      // Status set strobes, bits 7:3
    logic [1:0] conv_set;     // Set strobes for bits 7:6
    logic       conv_done;    // Conversion finished pulse
  } periph_in_t;
endpackage : sfr_space_pkg

// File: test/sfr_space_monitor.sv
// Port checker for the special-register decoder.
// Assumes bind onto sfr_space_decoder; one clock domain.
`timescale 1ns/1ns
`default_nettype none
// ==========
// Checker
module sfr_space_monitor (
  input wire logic                    ref_clk,     // Core clock
  input wire logic                    rst,         // Async reset
  input wire sfr_space_pkg::sfr_req_t req,         // Core access
  input wire logic                    timed_access_open, // Unlock window
  input wire logic [7:0]              rdata,       // Read data
  input wire logic                    rvalid,      // Read valid
  input wire logic                    prot_we,     // Protected strobe
  input wire logic [7:0]              prot_addr,   // Protected address
  input wire logic [63:0]             ctrl_out,    // Control image
  input wire logic                    conv_start   // Start pulse
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic tk;
  logic rd;
  // Taken access and taken byte or bit read
  assign tk = req.valid && req.direct && req.addr >= 8'h80;
  assign rd = tk && !req.write;
  a_read_answered: assert property (rd |=> rvalid)
    else $error("read not answered");
  a_rvalid_cause: assert property (rvalid |-> $past(rd))
    else $error("read valid without request");
  a_indirect_ignored: assert property (req.valid && !req.direct |=> !rvalid && !prot_we)
    else $error("indirect access answered");
  a_low_ignored: assert property (req.addr < 8'h80 |=> !rvalid && !prot_we)
    else $error("low address answered");
  a_locked_write: assert property (!timed_access_open |=> !prot_we)
    else $error("protected write while locked");
  a_unlocked_write: assert property (tk && req.write && !req.bit_op && req.addr == 8'h9c
    && timed_access_open |=> prot_we && prot_addr == 8'h9c)
    else $error("protected write lost");
  a_conv_start: assert property (tk && req.write && !req.bit_op && req.addr == 8'hf8
    && req.wdata[3] |=> conv_start)
    else $error("conversion start missing");
  // Only the addressed bit may move; the rest hold
  a_bit_only: assert property (tk && req.write && req.bit_op && req.addr[7:3] == 5'h1d
    |=> ctrl_out[7:0] == (($past(ctrl_out[7:0]) & ~(8'h01 << $past(req.addr[2:0])))
    | ({7'h00, $past(req.wdata[0])} << $past(req.addr[2:0]))))
    else $error("bit write disturbed other bits");
  a_reserved_zero: assert property (rd && !req.bit_op && req.addr inside {[8'hf9:8'hfe]}
    |=> rdata == 8'h00)
    else $error("reserved read not zero");
  c_read: cover property (rd);
  c_prot: cover property (prot_we);
  c_conv: cover property (conv_start);
endmodule : sfr_space_monitor
bind sfr_space_decoder sfr_space_monitor mon (.ref_clk(ref_clk), .rst(rst), .req(req),
  .timed_access_open(timed_access_open), .rdata(rdata), .rvalid(rvalid), .prot_we(prot_we),
  .prot_addr(prot_addr), .ctrl_out(ctrl_out), .conv_start(conv_start));
`default_nettype wire

// File: test/core_model.sv
// Model of the core issuing direct-address register accesses.
// Assumes read data is registered on the taking edge and read half a cycle later.
`timescale 1ns/1ns
`default_nettype none
// ==========
// Core model
module core_model (
  input wire logic                   ref_clk, // Core clock
  output var sfr_space_pkg::sfr_req_t req,    // Access to decoder
  input wire logic [7:0]             rdata,   // Read data
  input wire logic                   rvalid   // Read valid
);
  initial req = '0;
  // One access per call; an idle cycle keeps each edge to one assignment
  task automatic acc(input logic w, d, b, input logic [7:0] a, v,
                     output logic [7:0] q, output logic ok);
    @(negedge ref_clk);
    req = {1'b1, w, d, b, a, v};
    @(negedge ref_clk);
    req = {1'b0, ~req[18:0]}; // Stale fields inverted so nothing lingers
    q = rdata;
    ok = rvalid;
  endtask : acc
endmodule : core_model
`default_nettype wire

// File: test/special_register_space_decoder_bench.sv
// Self-checking bench for the special-register decoder.
// Assumes core_model drives the access port and the monitor is bound.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("Error %0t: got %h expected %h", $time, g, e); end end
// ==========
// Bench
module special_register_space_decoder_bench;
  logic ref_clk, rst, timed_access_open, rvalid, prot_we, conv_start, ok;
  logic [7:0] rdata, prot_addr, prot_wdata, q;
  logic [63:0] ctrl_out;
  sfr_space_pkg::sfr_req_t req;
  sfr_space_pkg::periph_in_t periph;
  int failures = 0;
  int compares = 0;
  logic [7:0] regs [19] = '{8'he4, 8'he5, 8'he6, 8'he7, 8'hed, 8'hee, 8'he8, 8'he9, 8'hea,
    8'heb, 8'hec, 8'hf0, 8'hf3, 8'hf4, 8'hf5, 8'hf6, 8'hf7, 8'hf8, 8'hff};
  logic [7:0] rw [10] = '{8'he8, 8'he9, 8'heb, 8'hec, 8'hf0, 8'hf3, 8'hf5, 8'hf6, 8'hf7, 8'hff};
  logic [7:0] prot [6] = '{8'hd8, 8'hab, 8'ha3, 8'ha4, 8'h9c, 8'h9f};
  sfr_space_decoder uut (.ref_clk(ref_clk), .rst(rst), .req(req),
    .timed_access_open(timed_access_open), .periph(periph), .rdata(rdata), .rvalid(rvalid),
    .prot_we(prot_we), .prot_addr(prot_addr), .prot_wdata(prot_wdata), .ctrl_out(ctrl_out),
    .conv_start(conv_start));
  core_model core (.ref_clk(ref_clk), .req(req), .rdata(rdata), .rvalid(rvalid));
  // Capture registers read back their own address as live data
  function automatic logic [7:0] rst_val(logic [7:0] a);
    if (a inside {[8'he4:8'he7], 8'hed, 8'hee}) return a;
    return (a == 8'hf3) ? 8'h04 : 8'h00;
  endfunction : rst_val
  task automatic wr(input logic [7:0] a, v);
    core.acc(1'b1, 1'b1, 1'b0, a, v, q, ok);
  endtask : wr
  task automatic bw(input logic [7:0] a, input logic v);
    core.acc(1'b1, 1'b1, 1'b1, a, {7'h00, v}, q, ok);
  endtask : bw
  task automatic rd(input logic [7:0] a, e);
    core.acc(1'b0, 1'b1, 1'b0, a, 8'h00, q, ok);
    `CHK({ok, q}, {1'b1, e})
  endtask : rd
  task automatic report_and_stop;
    if (failures == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    timed_access_open = 1'b0;
    periph = {8'he4, 8'he5, 8'he6, 8'he7, 8'hed, 8'hee, 16'h0000};
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    foreach (regs[i]) rd(regs[i], rst_val(regs[i]));
    foreach (rw[i]) wr(rw[i], 8'ha5);
    foreach (rw[i]) rd(rw[i], 8'ha5);
    `CHK(ctrl_out, {8{8'ha5}})
    wr(8'hf4, 8'hff);
    rd(8'hf4, 8'hf8);
    wr(8'he4, 8'h00);
    rd(8'he4, 8'he4);
    bw(8'he9, 1'b1);
    bw(8'hef, 1'b0);
    rd(8'he8, 8'h27);
    bw(8'hf3, 1'b1);
    rd(8'hf0, 8'had);
    core.acc(1'b0, 1'b1, 1'b1, 8'he9, 8'h00, q, ok);
    `CHK({ok, q}, {1'b1, 8'h01})
    core.acc(1'b1, 1'b0, 1'b0, 8'he9, 8'h00, q, ok);
    rd(8'he9, 8'ha5);
    core.acc(1'b0, 1'b1, 1'b0, 8'h69, 8'h00, q, ok);
    `CHK(ok, 1'b0)
    wr(8'h69, 8'h00);
    rd(8'he9, 8'ha5);
    // Unmapped here but not reserved; reserved slots are only ever read
    wr(8'hd0, 8'hff);
    rd(8'hd0, 8'h00);
    rd(8'hf9, 8'h00);
    foreach (prot[i]) begin
      timed_access_open = 1'b0;
      wr(prot[i], 8'h3c);
      `CHK(prot_we, 1'b0)
      timed_access_open = 1'b1;
      wr(prot[i], 8'h3c);
      `CHK({prot_we, prot_addr, prot_wdata}, {1'b1, prot[i], 8'h3c})
    end
    wr(8'hf8, 8'h08);
    `CHK(conv_start, 1'b1)
    wr(8'hf4, 8'h00);
    // Some strobes of each set group and the done pulse for one edge while the bus idles
    periph[15:0] = {8'h81, 5'h11, 2'b10, 1'b1};
    @(negedge ref_clk);
    periph[15:0] = 16'h0000;
    rd(8'hea, 8'h81);
    rd(8'hf4, 8'h88);
    rd(8'hf8, 8'h90);
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    rd(8'hf3, 8'h04);
    report_and_stop();
  end
endmodule : special_register_space_decoder_bench
`default_nettype wire
